// File: common/codec_pkg.sv
package codec_pkg;

	////////////////////////////////////////////////////////////////////////////////////////////
	// register map (byte addresses on the apb word bus)
	localparam int unsigned APB_AW        = 12;
	localparam logic [11:0] CTRL_OFF      = 12'h000;
	localparam logic [11:0] STATUS_OFF    = 12'h004;
	localparam int unsigned CTRL_CODE_BIT = 0;
	localparam int unsigned CTRL_LOOP_BIT = 1;
	localparam logic [1:0]  CTRL_RESET    = 2'h1;
	localparam int unsigned STAT_ALARM    = 0;
	localparam int unsigned STAT_ERROR    = 1;
	localparam int unsigned STAT_LOOP     = 2;
	localparam int unsigned STAT_CODE     = 3;

	////////////////////////////////////////////////////////////////////////////////////////////
	// pipeline depths and thresholds
	localparam int unsigned ENC_DEPTH      = 4;
	localparam int unsigned DEC_DEPTH      = 3;
	localparam logic [1:0]  ZERO_LIMIT     = 2'h3;
	localparam logic [1:0]  SAME_POL_LIMIT = 2'h3;

	////////////////////////////////////////////////////////////////////////////////////////////
	// bit positions inside the synchroniser bundle
	localparam int unsigned SYNC_W       = 6;
	localparam int unsigned SX_ENC_CLK   = 0;
	localparam int unsigned SX_NRZ       = 1;
	localparam int unsigned SX_DEC_CLK   = 2;
	localparam int unsigned SX_POS       = 3;
	localparam int unsigned SX_NEG       = 4;
	localparam int unsigned SX_ALARM_RST = 5;

	// encoder symbol classes: fill is the balancing mark ahead of a violation
	typedef enum logic [1:0] {
		SYM_SPACE,
		SYM_MARK,
		SYM_FILL,
		SYM_VIOL
	} sym_t;

endpackage : codec_pkg

// File: core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned W = 1
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rstn,
	// raw pins
	input  wire logic [W-1:0] pin,
	// synchronised level and edges
	output logic      [W-1:0] lvl,
	output logic      [W-1:0] rise,
	output logic      [W-1:0] fall
);
	logic [W-1:0] meta_q;
	logic [W-1:0] lvl_q;
	logic [W-1:0] prev_q;

	// meta_q feeds lvl_q alone; edges come from the settled stages
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= '0;
			lvl_q  <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= pin;
			lvl_q  <= meta_q;
			prev_q <= lvl_q;
		end
	end

	assign lvl  = lvl_q;
	assign rise = lvl_q & ~prev_q;
	assign fall = ~lvl_q & prev_q;

endmodule : pin_sync

// File: core/line_codec.sv
`timescale 1ns/1ps
// Overview of operation
// - in hdb3 mode, three same-polarity marks raise violation error
// - regenerated clock ORs line inputs or outputs
// - positive/negative inputs are marks; swap-tolerant
// - sample line inputs on decoder clock rise
// - encoder and decoder run on independent clocks
// - loopback routes encoder outputs to decoder
// - loopback nrz in to out: 7.5 periods
// - line pulses launch on encoder clock rise
// - pulse lasts the encoder clock high phase
// - encoder symbol appears on the line 4.5 periods after input capture
// - decoder bit appears three periods after sample
// - line has positive, negative and space states
// - ones become alternating marks, except violations
// - first zero space only when balance allows
// - second and third zeros always spaces
// - fourth zero is a same-polarity violation mark
// - code select high hdb3, low ami
// - capture nrz input on encoder clock fall
// - alarm after two periods under three zeros
// - alarm reset low clears counter, may clear alarm
module line_codec
	import codec_pkg::*;
(
	// system clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rstn,
	// apb register port
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [codec_pkg::APB_AW-1:0] paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// encoder side
	input  wire logic                     enc_clk,
	input  wire logic                     nrz_in,
	output logic                          line_pos_out,
	output logic                          line_neg_out,
	// decoder side
	input  wire logic                     dec_clk,
	input  wire logic                     line_pos_in,
	input  wire logic                     line_neg_in,
	output logic                          nrz_out,
	output logic                          regen_clk,
	output logic                          violation_error,
	// all-ones monitor
	input  wire logic                     alarm_count_reset,
	output logic                          all_ones_alarm
);
	import codec_pkg::*;

	logic [SYNC_W-1:0]    s_lvl;
	logic [SYNC_W-1:0]    s_rise;
	logic [SYNC_W-1:0]    s_fall;
	logic [1:0]           ctrl_q;
	logic                 code_select;
	logic                 loop_enable;
	sym_t [ENC_DEPTH-1:0] enc_st_q;
	sym_t [ENC_DEPTH-1:0] enc_st_d;
	sym_t                 enc_new;
	sym_t                 enc_out;
	logic                 enc_run;
	logic                 par_q;
	logic                 par_d;
	logic                 enc_pol_q;
	logic                 out_pol;
	logic                 sym_pos_q;
	logic                 sym_neg_q;
	logic                 line_pos_q;
	logic                 line_neg_q;
	logic                 dec_a;
	logic                 dec_b;
	logic                 dec_mark;
	logic                 dec_same;
	logic                 dec_viol;
	logic [1:0]           run_q;
	logic [1:0]           run_d;
	logic                 dec_pol_q;
	logic                 dec_seen_q;
	logic [DEC_DEPTH-1:0] dec_bits_q;
	logic                 nrz_q;
	logic                 err_q;
	logic                 regen_q;
	logic [1:0]           zero_cnt_q;
	logic                 low_prev_q;
	logic                 alarm_q;
	logic                 enc_rise;
	logic                 enc_fall;
	logic                 dec_rise;
	logic                 arst_lvl;
	logic                 apb_wr;
	logic                 apb_hit;

	////////////////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: both link clocks are sampled, never used as clocks

	pin_sync #(
		.W (SYNC_W)
	) u_sync (
		.mclk (mclk),
		.rstn (rstn),
		.pin  ({alarm_count_reset, line_neg_in, line_pos_in, dec_clk, nrz_in, enc_clk}),
		.lvl  (s_lvl),
		.rise (s_rise),
		.fall (s_fall)
	);

	// nrz and clock share the synchroniser depth, so setup before the edge still holds
	assign enc_rise = s_rise[SX_ENC_CLK];
	assign enc_fall = s_fall[SX_ENC_CLK];
	assign dec_rise = s_rise[SX_DEC_CLK];
	assign arst_lvl = s_lvl[SX_ALARM_RST];

	////////////////////////////////////////////////////////////////////////////////////////////
	// apb slave: zero wait states, unmapped addresses answer with an error

	assign code_select = ctrl_q[CTRL_CODE_BIT];
	assign loop_enable = ctrl_q[CTRL_LOOP_BIT];
	assign pready      = 1'b1;
	assign apb_wr      = psel && penable && pwrite;

	always_comb begin
		apb_hit = 1'b1;
		prdata  = '0;
		if (paddr == CTRL_OFF) begin
			prdata[1:0] = ctrl_q;
		end else if (paddr == STATUS_OFF) begin
			prdata[STAT_ALARM] = alarm_q;
			prdata[STAT_ERROR] = err_q;
			prdata[STAT_LOOP]  = loop_enable;
			prdata[STAT_CODE]  = code_select;
		end else begin
			apb_hit = 1'b0;
		end
	end

	assign pslverr = psel && penable && !apb_hit;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RESET;
		end else if (apb_wr && paddr == CTRL_OFF) begin
			ctrl_q <= pwdata[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////
	// encoder: four-symbol lookahead so a zero run can rewrite its first slot

	always_comb begin
		enc_new  = nrz_in_sym(s_lvl[SX_NRZ]);
		enc_out  = enc_st_q[ENC_DEPTH-1];
		enc_run  = code_select && (enc_new == SYM_SPACE);
		for (int i = 0; i < ENC_DEPTH - 1; i++) begin
			if (enc_st_q[i] != SYM_SPACE) begin
				enc_run = 1'b0;
			end
		end
		// mark parity since the last violation, counting the symbol now leaving
		if (enc_out == SYM_VIOL) begin
			par_d = 1'b0;
		end else if (enc_out != SYM_SPACE) begin
			par_d = ~par_q;
		end else begin
			par_d = par_q;
		end
		enc_st_d = {enc_st_q[ENC_DEPTH-2:0], enc_new};
		if (enc_run) begin
			enc_st_d[0] = SYM_VIOL;
			// even count since last violation: balance with a fill mark
			enc_st_d[ENC_DEPTH-1] = par_d ? SYM_SPACE : SYM_FILL;
		end
		// violations repeat the last polarity, everything else alternates
		out_pol = (enc_out == SYM_VIOL) ? enc_pol_q : ~enc_pol_q;
	end

	function automatic sym_t nrz_in_sym(input logic bit_in);
		sym_t s;
		s = bit_in ? SYM_MARK : SYM_SPACE;
		return s;
	endfunction : nrz_in_sym

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			enc_st_q  <= {ENC_DEPTH{SYM_SPACE}};
			par_q     <= 1'b0;
			enc_pol_q <= 1'b0;
			sym_pos_q <= 1'b0;
			sym_neg_q <= 1'b0;
		end else if (enc_fall) begin
			enc_st_q  <= enc_st_d;
			par_q     <= par_d;
			sym_pos_q <= (enc_out != SYM_SPACE) && out_pol;
			sym_neg_q <= (enc_out != SYM_SPACE) && !out_pol;
			if (enc_out != SYM_SPACE) begin
				enc_pol_q <= out_pol;
			end
		end
	end

	// return-to-zero: pulse opens on the rise and closes on the next fall
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			line_pos_q <= 1'b0;
			line_neg_q <= 1'b0;
		end else if (enc_rise) begin
			line_pos_q <= sym_pos_q;
			line_neg_q <= sym_neg_q;
		end else if (enc_fall) begin
			line_pos_q <= 1'b0;
			line_neg_q <= 1'b0;
		end
	end

	assign line_pos_out = line_pos_q;
	assign line_neg_out = line_neg_q;

	////////////////////////////////////////////////////////////////////////////////////////////
	// decoder: always paced by the decoder clock, loopback only swaps the data source

	// a pulse launched on this very edge must be seen, or a shared clock never catches it
	assign dec_a    = loop_enable ? (enc_rise ? sym_pos_q : line_pos_q) : s_lvl[SX_POS];
	assign dec_b    = loop_enable ? (enc_rise ? sym_neg_q : line_neg_q) : s_lvl[SX_NEG];
	assign dec_mark = dec_a || dec_b;
	// polarity is only compared with the previous mark, so swapped inputs decode alike
	assign dec_same = dec_mark && dec_seen_q && (dec_a == dec_pol_q);
	assign dec_viol = code_select && dec_same;

	always_comb begin
		run_d = run_q;
		if (dec_mark) begin
			if (!dec_same) begin
				run_d = 2'h1;
			end else if (run_q != SAME_POL_LIMIT) begin
				run_d = run_q + 2'h1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			dec_bits_q <= '0;
			nrz_q      <= 1'b0;
			dec_pol_q  <= 1'b0;
			dec_seen_q <= 1'b0;
			run_q      <= 2'h0;
			err_q      <= 1'b0;
		end else if (dec_rise) begin
			// a violation removes itself and the fill three slots back
			nrz_q      <= dec_viol ? 1'b0 : dec_bits_q[DEC_DEPTH-1];
			dec_bits_q <= dec_viol ? '0 : {dec_bits_q[DEC_DEPTH-2:0], dec_mark};
			run_q      <= run_d;
			err_q      <= code_select && dec_mark && (run_d == SAME_POL_LIMIT);
			if (dec_mark) begin
				dec_pol_q  <= dec_a;
				dec_seen_q <= 1'b1;
			end
		end
	end

	// regenerated clock follows the line marks with one register of delay
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			regen_q <= 1'b0;
		end else begin
			regen_q <= loop_enable ? (line_pos_q || line_neg_q)
			                       : (s_lvl[SX_POS] || s_lvl[SX_NEG]);
		end
	end

	assign nrz_out         = nrz_q;
	assign regen_clk       = regen_q;
	assign violation_error = err_q;

	////////////////////////////////////////////////////////////////////////////////////////////
	// all-ones monitor: counts decoded zeros, saturating at the threshold

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			zero_cnt_q <= 2'h0;
		end else if (!arst_lvl) begin
			zero_cnt_q <= 2'h0;
		end else if (dec_rise && !nrz_q && zero_cnt_q != ZERO_LIMIT) begin
			zero_cnt_q <= zero_cnt_q + 2'h1;
		end
	end

	// verdict taken on the falling edge of the reset strobe, before the clear lands
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			low_prev_q <= 1'b0;
			alarm_q    <= 1'b0;
		end else if (s_fall[SX_ALARM_RST]) begin
			low_prev_q <= (zero_cnt_q != ZERO_LIMIT);
			if (zero_cnt_q == ZERO_LIMIT) begin
				alarm_q <= 1'b0;
			end else if (low_prev_q) begin
				alarm_q <= 1'b1;
			end
		end
	end

	assign all_ones_alarm = alarm_q;

	////////////////////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	AST_LINE_EXCL: assert property (!(line_pos_q && line_neg_q))
		else $error("both line outputs high");

	AST_PULSE_LAUNCH: assert property ($rose(line_pos_q) || $rose(line_neg_q)
		|-> $past(enc_rise))
		else $error("line pulse launched off the encoder rise");

	AST_RZ_CLOSE: assert property (enc_fall |=> !line_pos_q && !line_neg_q)
		else $error("line pulse outlived encoder high phase");

	AST_AMI_PLAIN: assert property (!code_select && enc_fall
		|=> enc_st_q[0] != SYM_VIOL && enc_st_q[ENC_DEPTH-1] != SYM_FILL)
		else $error("substitution in ami mode");

	AST_HDB3_RUN: assert property (code_select && enc_fall && enc_run
		|=> enc_st_q[0] == SYM_VIOL && enc_st_q[1] == SYM_SPACE
		&& enc_st_q[2] == SYM_SPACE)
		else $error("zero run not replaced by violation pattern");

	AST_ERR_EDGE: assert property ($changed(err_q) |-> $past(dec_rise))
		else $error("violation error moved without decoder edge");

	AST_ERR_THIRD: assert property (dec_rise && code_select && dec_same
		&& run_q == 2'h2 |=> err_q)
		else $error("third same-polarity mark not flagged");

	AST_NRZ_EDGE: assert property ($changed(nrz_q) |-> $past(dec_rise))
		else $error("nrz output moved without decoder edge");

	AST_LOOP_SRC: assert property (loop_enable && $stable(loop_enable)
		|-> regen_q == $past(line_pos_q || line_neg_q))
		else $error("regenerated clock not from encoder in loopback");

	AST_CNT_CLEAR: assert property (!arst_lvl |=> zero_cnt_q == 2'h0)
		else $error("zero counter not held clear");

	AST_ALARM_EDGE: assert property ($changed(alarm_q) |-> $past(s_fall[SX_ALARM_RST]))
		else $error("alarm moved off the reset strobe fall");

endmodule : line_codec

// File: verification/line_partner.sv
`timescale 1ns/1ps
// far-end line interface: makes the link clock and relays captured marks back
module line_partner (
	// control from the bench
	input  wire logic run,
	input  wire logic swap,
	input  wire logic bad,
	input  wire logic loop,
	// line side
	input  wire logic pos_out,
	input  wire logic neg_out,
	output logic      lclk,
	output logic      pos_in,
	output logic      neg_in
);
	logic [1:0] sym;

	// the clock keeps running in every frame, loopback too, and stops low between frames
	initial begin
		lclk = 1'b0;
		#3;
		forever #40 if (run || lclk) lclk = ~lclk;
	end

	initial {pos_in, neg_in} = 2'h0;

	always @(negedge lclk) begin
		sym = {pos_out, neg_out};
		if (bad) sym = {|sym, 1'b0};
		// in loopback the pins must be ignored, so feed them the opposite
		if (loop) sym = ~sym;
		if (swap) sym = {sym[0], sym[1]};
		{pos_in, neg_in} <= sym;
	end
endmodule : line_partner

// File: verification/test_hdb3_ami_line_codec.sv
`timescale 1ns/1ps
module test_hdb3_ami_line_codec;
	import codec_pkg::*;
	logic        mclk, rstn, psel, penable, pwrite, nrz_in, alarm_count_reset;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, lclk, pos_o, neg_o, pos_i, neg_i;
	logic        nrz_out, regen_clk, viol, alarm;
	logic        run = 1'b0, swap = 1'b0, bad = 1'b0, loop_q = 1'b0, hdb = 1'b1;
	int          n_mismatch = 0, n_checks = 0, seed = 84, idx = 0, nv = 0;
	int          pol, lastpol = -1, lastv = 0;
	int          sy[$];
	logic        dc[$], sent[$], exp_q[$];

	always #5 mclk = ~mclk;

	line_codec line_codec_inst (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .enc_clk(lclk), .nrz_in(nrz_in), .line_pos_out(pos_o),
		.line_neg_out(neg_o), .dec_clk(lclk), .line_pos_in(pos_i), .line_neg_in(neg_i),
		.nrz_out(nrz_out), .regen_clk(regen_clk), .violation_error(viol),
		.alarm_count_reset(alarm_count_reset), .all_ones_alarm(alarm));

	line_partner line_partner_inst (.run(run), .swap(swap), .bad(bad), .loop(loop_q),
		.pos_out(pos_o), .neg_out(neg_o), .lclk(lclk), .pos_in(pos_i), .neg_in(neg_i));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude;
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] er, input logic ee);
		int k;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge mclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k >= 16) begin
			n_mismatch++;
			conclude();
		end
		if (!w) check(prdata, er);
		check(32'(pslverr), 32'(ee));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// one frame: link clock runs for n bits; mode 0 random, 1 ones, 2 zeros
	task automatic phase(input logic [31:0] ctl, input logic sw, input logic bd,
		input int mode, input int n, input logic al);
		logic b;
		apb(1'b1, CTRL_OFF, ctl, 32'h0, 1'b0);
		swap = sw;
		bad = bd;
		loop_q = ctl[CTRL_LOOP_BIT];
		hdb = ctl[CTRL_CODE_BIT];
		idx = 0;
		sy.delete();
		dc.delete();
		sent.delete();
		exp_q.delete();
		run = 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge lclk);
			@(posedge mclk);
			b = (mode == 0) ? (($random(seed) & 3) == 0) : (mode == 1);
			nrz_in <= b;
			alarm_count_reset <= !(al && i % 20 == 19);
			sent.push_back(b);
			exp_q.push_back(b);
		end
		@(negedge lclk);
		run = 1'b0;
		alarm_count_reset <= 1'b1;
	endtask : phase

	////////////////////////////////////////////////////////////////////////////////
	// low phase of the link clock: return-to-zero outputs must be idle
	always @(posedge lclk) begin
		check(32'({pos_o, neg_o}), 32'h0);
		if (!loop_q) check(32'(regen_clk), 32'(pos_i | neg_i));
	end

	// symbol j carries bit j-5; a violation retracts the fill three symbols back,
	// so a bit is only decided once three later symbols are in
	always @(negedge lclk) begin
		pol = pos_o ? 1 : (neg_o ? -1 : 0);
		sy.push_back(pol);
		dc.push_back(pol != 0);
		check(32'(pos_o & neg_o), 32'h0);
		if (pol != 0 && pol == lastpol) begin
			if (idx >= 5) begin
				check(32'(hdb), 32'h1);
				check(32'(sy[idx-1] | sy[idx-2]), 32'h0);
				if (lastv != 0) check(32'(pol), 32'(-lastv));
			end
			lastv = pol;
			dc[idx] = 1'b0;
			if (idx >= 3) dc[idx-3] = 1'b0;
		end
		if (pol != 0) lastpol = pol;
		if (hdb && idx >= 8) check(32'((sy[idx] | sy[idx-1] | sy[idx-2] | sy[idx-3]) != 0), 32'h1);
		if (idx >= 8) check(32'(dc[idx-3]), 32'(sent[idx-8]));
		if (idx >= (loop_q ? 8 : 9) && !bad && exp_q.size() > 0) check(32'(nrz_out), 32'(exp_q.pop_front()));
		if (hdb && !bad && idx >= 8) check(32'(viol), 32'h0);
		if (bad && viol) nv++;
		if (loop_q) check(32'(regen_clk), 32'(pos_o | neg_o));
		idx++;
	end

	initial begin
		repeat (60000) @(posedge mclk);
		n_mismatch++;
		conclude();
	end

	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		nrz_in = 1'b0;
		alarm_count_reset = 1'b1;
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		apb(1'b0, CTRL_OFF, 32'h0, 32'(CTRL_RESET), 1'b0);
		apb(1'b0, STATUS_OFF, 32'h0, 32'h1 << STAT_CODE, 1'b0);
		apb(1'b1, CTRL_OFF, 32'hffff_ffff, 32'h0, 1'b0);
		apb(1'b0, STATUS_OFF, 32'h0, 32'h1 << STAT_CODE | 32'h1 << STAT_LOOP, 1'b0);
		apb(1'b1, STATUS_OFF, 32'h0, 32'h0, 1'b0);
		apb(1'b1, 12'h008, 32'h3, 32'h0, 1'b1);
		apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
		apb(1'b0, CTRL_OFF, 32'h0, 32'h3, 1'b0);
		phase(32'h1, 1'b0, 1'b0, 0, 80, 1'b0);
		phase(32'h0, 1'b1, 1'b0, 0, 50, 1'b0);
		phase(32'h0, 1'b0, 1'b0, 0, 30, 1'b0);
		phase(32'h3, 1'b0, 1'b0, 0, 60, 1'b0);
		phase(32'h1, 1'b0, 1'b1, 1, 30, 1'b0);
		check(32'(nv > 0), 32'h1);
		phase(32'h1, 1'b0, 1'b0, 1, 65, 1'b1);
		check(32'(alarm), 32'h1);
		phase(32'h1, 1'b0, 1'b0, 2, 45, 1'b1);
		check(32'(alarm), 32'h0);
		conclude();
	end
endmodule : test_hdb3_ami_line_codec
